// file: disk_cfg_checker_properties.sv
// port-level property checker for the disk configuration bank
`timescale 1ns/1ns
module disk_cfg_checker (
  // clock, reset and bus answer
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o,
  input wire wb_err_o,
  // host and pin side
  input wire aen,
  input wire disk1_cycle,
  input wire disk2_cycle,
  input wire media_id0_in,
  input wire media_id0_out,
  input wire [1:0] boot_drive,
  input wire boot_none,
  input wire drive_chip_select_a_n,
  input wire drive_chip_select_b_n,
  input wire first_buffer_enable_n,
  input wire second_buffer_enable_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // -----------------------------
  // bus handshake steps
  // -----------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_ans;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans) else $error("request not answered once");
  // reset has its own disable so the idle pins are seen during it
  a_rst_idle: assert property (disable iff (1'b0) rst |=> drive_chip_select_a_n && !wb_ack_o) else $error("reset pins");
  a_cs_aen_off: assert property (aen |=> drive_chip_select_a_n && drive_chip_select_b_n) else $error("select on dma");
  a_buf_disk1: assert property (disk1_cycle |=> !first_buffer_enable_n) else $error("first enable off");
  a_buf_second: assert property (!second_buffer_enable_n |-> $past(disk2_cycle)) else $error("second enable");
  a_buf_idle: assert property (!disk1_cycle && !disk2_cycle |=> first_buffer_enable_n && second_buffer_enable_n)
    else $error("enable without cycle");
  a_boot_code: assert property (boot_none == boot_drive[1]) else $error("boot none mismatch");
  // output may only move after an input move, a write or a reset
  a_mid0_cause: assert property ($changed(media_id0_out) |-> $past(media_id0_in) != $past(media_id0_in, 2)
    || $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2) || $past(rst, 2)) else $error("media id moved");
endmodule // disk_cfg_checker

// file: disk_ldev_regs.vh
// register offsets, field positions, reset values for the disk logical-device configuration bank
`ifndef DISK_LDEV_REGS_VH
`define DISK_LDEV_REGS_VH
// word offsets (byte address = index * 4); logical device number sits in bits 11:10
`define LDEV_FLOPPY 2'h0
`define LDEV_DISK1 2'h1
`define LDEV_DISK2 2'h2
`define IDX_MODE 8'hF0
`define IDX_OPTION 8'hF1
`define IDX_TYPE 8'hF2
`define IDX_RSVD 8'hF3
`define IDX_DRIVE0 8'hF4
`define IDX_DRIVE1 8'hF5
`define IDX_CS_A 8'hF0
`define IDX_CS_B 8'hF1
`define IDX_DISK2_MODE 8'hF0
`define IDX_BASE_A 8'hF8
`define IDX_BASE_B 8'hF9
`define IDX_STATUS 8'hFA
// reset values
`define RST_MODE 8'h0E
`define RST_OPTION 8'h00
`define RST_TYPE 8'hFF
`define RST_DRIVE 8'h00
`define RST_CS_A 8'h0C
`define RST_CS_B 8'h00
`define RST_DISK2_MODE 8'h00
`define RST_BASE 12'h000
// field masks and positions
`define DRIVE_WMASK 8'h5B
`define CS_WMASK 8'h1F
`define DISK2_WMASK 8'h01
`define OPT_DENS_HI 3
`define OPT_DENS_LO 2
`define OPT_MID0 4
`define OPT_MID1 5
`define OPT_BOOT_HI 7
`define OPT_BOOT_LO 6
`define DRV_PRECOMP 6
`define CS_MASK_HI 4
`define CS_MASK_LO 2
`define ADDR_W 12
`endif

// file: disk_logical_device_config.v
// configuration register bank for the floppy and two disk logical devices, wishbone slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
`include "disk_ldev_regs.vh"

module disk_logical_device_config (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire soft_rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // host isa bus side
  input wire [11:0] host_addr,
  input wire aen,
  input wire io_read_n,
  input wire io_write_n,
  input wire disk1_cycle,
  input wire disk2_cycle,
  // floppy side
  input wire density_normal,
  input wire media_id0_in,
  input wire media_id1_in,
  output reg density_out,
  output reg media_id0_out,
  output reg media_id1_out,
  output reg floppy_mode,
  output reg [1:0] boot_drive,
  output reg boot_none,
  output reg [1:0] drive0_type_select,
  output reg [1:0] drive1_type_select,
  output reg [1:0] drive0_rate_table_select,
  output reg [1:0] drive1_rate_table_select,
  output reg drive0_precomp_en,
  output reg drive1_precomp_en,
  // disk side
  output reg drive_chip_select_a_n,
  output reg drive_chip_select_b_n,
  output reg first_buffer_enable_n,
  output reg second_buffer_enable_n
);

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  // byte address = {device, index, 2'b00}; lanes 2 and 3 are ignored
  // device 0, floppy: F0 mode, F1 option, F2 type store, F3 reserved,
  //   F4 drive 0 settings, F5 drive 1 settings
  // device 1, disk 1: F0 select A decoder, F1 select B decoder,
  //   F8 base A, F9 base B (12 bits, lane 1 holds bits 11:8),
  //   FA read-only pin status: cs A, cs B, first, second enable
  // device 2, disk 2: F0 mode
  // any other pair answers with err and changes nothing
  // hard reset loads every register's reset value; soft reset only the disk 1 decoders
  // and bases, since those follow the host's software reset too

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  reg [7:0] floppy_mode_cfg_r;
  reg [7:0] floppy_option_cfg_r;
  reg [7:0] floppy_type_store_r;
  reg [7:0] floppy_drive_cfg_r [0:1];
  reg [7:0] disk1_cs0_decoder_r;
  reg [7:0] disk1_cs1_decoder_r;
  reg [7:0] disk2_mode_cfg_r;
  reg [11:0] cs_base_a_r;
  reg [11:0] cs_base_b_r;
  reg [31:0] rd_nxt;
  reg hit_nxt;
  wire req;
  wire wr_lo;
  wire wr_hi;
  wire [1:0] ldev;
  wire [7:0] idx;
  wire cs_a_hit;
  wire cs_b_hit;
  wire mid0_nxt;
  wire mid1_nxt;

  // index in bits 9:2, logical device number in bits 11:10
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign ldev = wb_adr_i[11:10];
  assign idx = wb_adr_i[9:2];
  assign wr_lo = req & wb_we_i & wb_sel_i[0] & hit_nxt;
  assign wr_hi = req & wb_we_i & wb_sel_i[1] & hit_nxt;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // masked compare of host address against base; reserved mask codes match nothing
  // the mask widens the window to 2^code bytes aligned on its own size;
  // codes 110 and 111 are refused outright rather than masking 6 or 7
  // bits, so a stray setting leaves the drive deselected, not wide open
  function addr_match;
    input [11:0] addr;
    input [11:0] base;
    input [2:0] code;
    reg [11:0] keep;
    begin
      keep = 12'hFFF << code;
      addr_match = (code <= 3'h5) && ((addr & keep) == (base & keep));
    end
  endfunction

  // qualification by aen and strobes; aen low means a cpu cycle
  // strobes are active low levels straight from the host bus; with
  // code 00 the select follows the address alone while aen is low
  function qual_ok;
    input [1:0] q;
    input aen_i;
    input rd_n;
    input wr_n;
    begin
      case (q)
        2'h0: qual_ok = ~aen_i;
        2'h1: qual_ok = ~aen_i & ~rd_n;
        2'h2: qual_ok = ~aen_i & ~wr_n;
        default: qual_ok = ~aen_i & (~rd_n | ~wr_n);
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // address decode and read mux
  // ------------------------------------------------------------
  // unmapped indexes answer with err instead of ack
  // the mux is cleared first so unused lanes and reserved bits read zero;
  // stored values are masked again here so a read never shows a bit
  // that the write path would not keep
  always @* begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case ({ldev, wb_adr_i[9:2]})
      {`LDEV_FLOPPY, `IDX_MODE}: rd_nxt[7:0] = floppy_mode_cfg_r;
      {`LDEV_FLOPPY, `IDX_OPTION}: rd_nxt[7:0] = floppy_option_cfg_r;
      {`LDEV_FLOPPY, `IDX_TYPE}: rd_nxt[7:0] = floppy_type_store_r;
      {`LDEV_FLOPPY, `IDX_RSVD}: rd_nxt[7:0] = 8'h00;
      {`LDEV_FLOPPY, `IDX_DRIVE0}: rd_nxt[7:0] = floppy_drive_cfg_r[0] & `DRIVE_WMASK;
      {`LDEV_FLOPPY, `IDX_DRIVE1}: rd_nxt[7:0] = floppy_drive_cfg_r[1] & `DRIVE_WMASK;
      {`LDEV_DISK1, `IDX_CS_A}: rd_nxt[7:0] = disk1_cs0_decoder_r & `CS_WMASK;
      {`LDEV_DISK1, `IDX_CS_B}: rd_nxt[7:0] = disk1_cs1_decoder_r & `CS_WMASK;
      {`LDEV_DISK1, `IDX_BASE_A}: rd_nxt[11:0] = cs_base_a_r;
      {`LDEV_DISK1, `IDX_BASE_B}: rd_nxt[11:0] = cs_base_b_r;
      {`LDEV_DISK1, `IDX_STATUS}: rd_nxt[3:0] = {second_buffer_enable_n, first_buffer_enable_n,
                                                  drive_chip_select_b_n, drive_chip_select_a_n};
      {`LDEV_DISK2, `IDX_DISK2_MODE}: rd_nxt[7:0] = disk2_mode_cfg_r & `DISK2_WMASK;
      default: hit_nxt = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // bus answer: one cycle after the request is seen
  // ------------------------------------------------------------
  // req is blocked while ack or err stands, so a master that holds
  // cyc one cycle too long is never answered twice for one request
  // read data is zero outside a read answer to keep the bus quiet
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & hit_nxt;
      wb_err_o <= req & ~hit_nxt;
      wb_dat_o <= (req & hit_nxt & ~wb_we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // floppy and disk 2 mode registers: hard reset only, soft reset is not looked at
  // ------------------------------------------------------------
  // writes land at the edge that takes the request, the same edge that raises
  // the ack; drive and disk2 registers keep only their writable fields
  always @(posedge clk) begin
    if (rst) begin
      floppy_mode_cfg_r <= `RST_MODE;
      floppy_option_cfg_r <= `RST_OPTION;
      floppy_type_store_r <= `RST_TYPE;
      floppy_drive_cfg_r[0] <= `RST_DRIVE;
      floppy_drive_cfg_r[1] <= `RST_DRIVE;
      disk2_mode_cfg_r <= `RST_DISK2_MODE;
    end else if (wr_lo) begin
      // option low bits are stored as written, host keeps them zero; disk2 upper bits are masked to zero
      if (ldev == `LDEV_FLOPPY && wb_adr_i[9:2] == `IDX_MODE)
        floppy_mode_cfg_r <= wb_dat_i[7:0];
      if (ldev == `LDEV_FLOPPY && wb_adr_i[9:2] == `IDX_OPTION)
        floppy_option_cfg_r <= wb_dat_i[7:0];
      if (ldev == `LDEV_FLOPPY && wb_adr_i[9:2] == `IDX_TYPE)
        floppy_type_store_r <= wb_dat_i[7:0];
      if (ldev == `LDEV_FLOPPY && wb_adr_i[9:2] == `IDX_DRIVE0)
        floppy_drive_cfg_r[0] <= wb_dat_i[7:0] & `DRIVE_WMASK;
      if (ldev == `LDEV_FLOPPY && wb_adr_i[9:2] == `IDX_DRIVE1)
        floppy_drive_cfg_r[1] <= wb_dat_i[7:0] & `DRIVE_WMASK;
      if (ldev == `LDEV_DISK2 && wb_adr_i[9:2] == `IDX_DISK2_MODE)
        disk2_mode_cfg_r <= wb_dat_i[7:0] & `DISK2_WMASK;
    end
  end

  // ------------------------------------------------------------
  // disk 1 decoders: hard reset and also soft reset
  // ------------------------------------------------------------
  // base registers take lane 0 for bits 7:0 and lane 1 for bits 11:8,
  // so software may move a base one byte at a time
  always @(posedge clk) begin
    if (rst | soft_rst) begin
      disk1_cs0_decoder_r <= `RST_CS_A;
      disk1_cs1_decoder_r <= `RST_CS_B;
      cs_base_a_r <= `RST_BASE;
      cs_base_b_r <= `RST_BASE;
    end else begin
      if (wr_lo && ldev == `LDEV_DISK1 && wb_adr_i[9:2] == `IDX_CS_A)
        disk1_cs0_decoder_r <= wb_dat_i[7:0] & `CS_WMASK;
      if (wr_lo && ldev == `LDEV_DISK1 && wb_adr_i[9:2] == `IDX_CS_B)
        disk1_cs1_decoder_r <= wb_dat_i[7:0] & `CS_WMASK;
      if (ldev == `LDEV_DISK1 && wb_adr_i[9:2] == `IDX_BASE_A) begin
        if (wr_lo)
          cs_base_a_r[7:0] <= wb_dat_i[7:0];
        if (wr_hi)
          cs_base_a_r[11:8] <= wb_dat_i[11:8];
      end
      if (ldev == `LDEV_DISK1 && wb_adr_i[9:2] == `IDX_BASE_B) begin
        if (wr_lo)
          cs_base_b_r[7:0] <= wb_dat_i[7:0];
        if (wr_hi)
          cs_base_b_r[11:8] <= wb_dat_i[11:8];
      end
    end
  end

  // ------------------------------------------------------------
  // derived outputs, all registered
  // ------------------------------------------------------------
  // decode is combinational here and registered below, so a select
  // follows the host address and strobes by exactly one clock
  assign cs_a_hit = addr_match(host_addr, cs_base_a_r, disk1_cs0_decoder_r[`CS_MASK_HI:`CS_MASK_LO]) &
                    qual_ok(disk1_cs0_decoder_r[1:0], aen, io_read_n, io_write_n);
  assign cs_b_hit = addr_match(host_addr, cs_base_b_r, disk1_cs1_decoder_r[`CS_MASK_HI:`CS_MASK_LO]) &
                    qual_ok(disk1_cs1_decoder_r[1:0], aen, io_read_n, io_write_n);
  assign mid0_nxt = media_id0_in ^ floppy_option_cfg_r[`OPT_MID0];
  assign mid1_nxt = media_id1_in ^ floppy_option_cfg_r[`OPT_MID1];

  // ------------------------------------------------------------
  // floppy pin levels
  // ------------------------------------------------------------
  // one cycle of latency on every pin output keeps them glitch free;
  // the price is that a forced density or an inverted media id shows
  // one clock after the option write or the input move, never sooner
  always @(posedge clk) begin
    if (rst) begin
      density_out <= 1'b0;
      media_id0_out <= 1'b0;
      media_id1_out <= 1'b0;
    end else begin
      // codes 00 and 01 both pass the normal level through
      case (floppy_option_cfg_r[`OPT_DENS_HI:`OPT_DENS_LO])
        2'h2: density_out <= 1'b1;
        2'h3: density_out <= 1'b0;
        default: density_out <= density_normal;
      endcase
      media_id0_out <= mid0_nxt;
      media_id1_out <= mid1_nxt;
    end
  end

  // ------------------------------------------------------------
  // floppy mode and boot choice
  // ------------------------------------------------------------
  // boot code 11 is undefined; it is treated like the reserved code
  // so that software which strays there never boots a drive by chance
  always @(posedge clk) begin
    if (rst) begin
      floppy_mode <= 1'b0;
      boot_drive <= 2'h0;
      boot_none <= 1'b0;
    end else begin
      floppy_mode <= floppy_mode_cfg_r[0];
      boot_drive <= floppy_option_cfg_r[`OPT_BOOT_HI:`OPT_BOOT_LO];
      boot_none <= floppy_option_cfg_r[`OPT_BOOT_HI];
    end
  end

  // ------------------------------------------------------------
  // per-drive fields
  // ------------------------------------------------------------
  // precomp enable is the inverse of the stored disable bit, so its
  // reset level is high: a cleared register means precompensation used
  always @(posedge clk) begin
    if (rst) begin
      drive0_type_select <= 2'h0;
      drive1_type_select <= 2'h0;
      drive0_rate_table_select <= 2'h0;
      drive1_rate_table_select <= 2'h0;
      drive0_precomp_en <= 1'b1;
      drive1_precomp_en <= 1'b1;
    end else begin
      drive0_type_select <= floppy_drive_cfg_r[0][1:0];
      drive1_type_select <= floppy_drive_cfg_r[1][1:0];
      drive0_rate_table_select <= floppy_drive_cfg_r[0][4:3];
      drive1_rate_table_select <= floppy_drive_cfg_r[1][4:3];
      drive0_precomp_en <= ~floppy_drive_cfg_r[0][`DRV_PRECOMP];
      drive1_precomp_en <= ~floppy_drive_cfg_r[1][`DRV_PRECOMP];
    end
  end

  // ------------------------------------------------------------
  // disk pins
  // ------------------------------------------------------------
  // chip selects and buffer enables are active low and idle high;
  // when disk2 mode bit 0 is set the second enable stays idle and
  // the first enable covers the data buffers of both drives
  always @(posedge clk) begin
    if (rst) begin
      drive_chip_select_a_n <= 1'b1;
      drive_chip_select_b_n <= 1'b1;
      first_buffer_enable_n <= 1'b1;
      second_buffer_enable_n <= 1'b1;
    end else begin
      drive_chip_select_a_n <= ~cs_a_hit;
      drive_chip_select_b_n <= ~cs_b_hit;
      first_buffer_enable_n <= ~(disk1_cycle | (disk2_cycle & disk2_mode_cfg_r[0]));
      second_buffer_enable_n <= ~(disk2_cycle & ~disk2_mode_cfg_r[0]);
    end
  end

endmodule // disk_logical_device_config

// file: disk_logical_device_config_tb.sv
// self-checking bench for the disk configuration bank
`timescale 1ns/1ns
module disk_logical_device_config_tb;
  logic clk = 0, rst = 1, soft_rst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic disk1_cycle = 0, disk2_cycle = 0, density_normal = 0, media_id0_in = 0, media_id1_in = 0, er;
  logic [11:0] wb_adr_i = 0, op_addr = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, q;
  logic [1:0] op = 0, k;
  wire [31:0] wb_dat_o;
  wire [11:0] host_addr;
  wire [1:0] boot_drive, drive0_type_select, drive1_type_select, drive0_rate_table_select, drive1_rate_table_select;
  wire wb_ack_o, wb_err_o, aen, io_read_n, io_write_n, density_out, media_id0_out, media_id1_out, floppy_mode;
  wire boot_none, drive0_precomp_en, drive1_precomp_en, drive_chip_select_a_n, drive_chip_select_b_n;
  wire first_buffer_enable_n, second_buffer_enable_n;
  int n_errors = 0, compares = 0;
  // reset table: {device, index, value}
  logic [17:0] rv [9] = '{18'h0F00E, 18'h0F100, 18'h0F2FF, 18'h0F300, 18'h0F400, 18'h0F500, 18'h1F00C, 18'h1F100,
    18'h2F000};
  disk_logical_device_config dut (.*);
  isa_host_model host (.*);
  always #2 clk = ~clk;
  // -----------------------------
  // shared tasks
  // -----------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one classic cycle; waits for ack or err under a bound
  task automatic wb(input logic [1:0] ld, input logic [7:0] ix, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {ld, ix, 2'h0};
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 64);
    q = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (n >= 64) n_errors++;
  endtask
  task automatic rd(input logic [1:0] ld, input logic [7:0] ix, input logic [7:0] e);
    wb(ld, ix, 0, 0);
    chk(q, {24'h0, e});
  endtask
  // pins follow one cycle after the register, so three edges is ample
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task automatic isa(input logic [1:0] o, input logic [11:0] a, input logic e);
    @(posedge clk);
    op <= o;
    op_addr <= a;
    repeat (3) @(posedge clk);
    chk(drive_chip_select_a_n, e);
    op <= 0;
  endtask
  task stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // -----------------------------
  // scenarios
  // -----------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 9; i++) rd(rv[i][17:16], rv[i][15:8], rv[i][7:0]);
    chk(floppy_mode, 0);
    wb(0, 8'hF3, 1, 32'hFF);
    rd(0, 8'hF3, 8'h00);
    wb(0, 8'hF2, 1, 32'h5A);
    rd(0, 8'hF2, 8'h5A);
    wb(0, 8'hF4, 1, 32'hFF);
    rd(0, 8'hF4, 8'h5B);
    wb(0, 8'hF5, 1, 32'h09);
    rd(0, 8'hF5, 8'h09);
    wb(1, 8'hF0, 1, 32'hFF);
    rd(1, 8'hF0, 8'h1F);
    wb(0, 8'hF6, 0, 0);
    chk(er, 1);
    wb(0, 8'hF0, 1, 32'h0F);
    settle;
    chk(floppy_mode, 1);
    chk({drive0_type_select, drive0_rate_table_select, drive0_precomp_en}, 5'h1E);
    chk({drive1_type_select, drive1_rate_table_select, drive1_precomp_en}, 5'h0B);
    // every density, polarity and boot code; normal level differs from the forced one
    for (int i = 0; i < 4; i++) begin
      k = i;
      density_normal <= k[0];
      media_id0_in <= 1;
      wb(0, 8'hF1, 1, {24'h0, k, k[1], k[0], k, 2'h0});
      settle;
      chk(density_out, (k == 2) ? 1 : (k == 3) ? 0 : k[0]);
      chk(media_id0_out, !k[0]);
      chk(media_id1_out, k[1]);
      chk({boot_none, boot_drive}, {k[1], k});
    end
    @(posedge clk);
    soft_rst <= 1;
    @(posedge clk);
    soft_rst <= 0;
    rd(0, 8'hF1, 8'hFC);
    rd(1, 8'hF0, 8'h0C);
    wb(1, 8'hF8, 1, 32'h1F0);
    wb(1, 8'hF0, 1, 32'h0D);
    isa(1, 12'h1F7, 0);
    isa(1, 12'h1F8, 1);
    isa(1, 12'h5F0, 1);
    isa(2, 12'h1F0, 1);
    isa(3, 12'h1F0, 1);
    wb(1, 8'hF0, 1, 32'h0F);
    isa(2, 12'h1F3, 0);
    wb(1, 8'hF0, 1, 32'h1A);
    isa(2, 12'h1F0, 1);
    wb(1, 8'hF8, 0, 0);
    chk(q, 32'h1F0);
    wb(1, 8'hF9, 1, 32'h1F0);
    isa(2, 12'h1F0, 1);
    chk(drive_chip_select_b_n, 0);
    disk2_cycle <= 1;
    settle;
    chk({first_buffer_enable_n, second_buffer_enable_n}, 2'h2);
    wb(2, 8'hF0, 1, 32'h01);
    settle;
    chk({first_buffer_enable_n, second_buffer_enable_n}, 2'h1);
    disk2_cycle <= 0;
    disk1_cycle <= 1;
    settle;
    chk({first_buffer_enable_n, second_buffer_enable_n}, 2'h1);
    stop_test;
  end
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule // disk_logical_device_config_tb
bind disk_logical_device_config disk_cfg_checker chk_i (.*);

// file: isa_host_model.sv
// host bus model: drives isa address, address enable and strobes
`timescale 1ns/1ns
module isa_host_model (
  // clock and command from the bench
  input wire clk,
  input wire [1:0] op,
  input wire [11:0] op_addr,
  // isa side
  output reg [11:0] host_addr = 12'h000,
  output reg aen = 1'b0,
  output reg io_read_n = 1'b1,
  output reg io_write_n = 1'b1
);
  // op 0 idle, 1 read, 2 write, 3 dma; idle flips the address so a stale value is never held
  always @(posedge clk) begin
    host_addr <= (op == 2'h0) ? ~host_addr : op_addr;
    aen <= (op == 2'h3);
    io_read_n <= !(op == 2'h1 || op == 2'h3);
    io_write_n <= (op != 2'h2);
  end
endmodule // isa_host_model
